//--- pkg/camera_port_defines.svh
`ifndef CAMERA_PORT_DEFINES_SVH
`define CAMERA_PORT_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_PIN_IO_CONFIG 14'h0004
`define IDX_PIN_IO_LEVEL 14'h0008
`define IDX_STRAP_READBACK 14'h000d
`define IDX_CAM_CLOCK_SELECT 14'h001c
`define IDX_CAM_STATUS_COMMAND 14'h1000
`define IDX_IRQ_STATUS 14'h1001
`define IDX_IRQ_ENABLE 14'h1002
`define IDX_IRQ_CLEAR 14'h1003

// field positions
`define BIT_AUX_PIN_TWO 2
`define BIT_STRAP_A 5
`define BIT_STRAP_B 6
`define BIT_CABLE_ABSENT 7
`define BIT_REMOTE_POWER 1
`define REV_LSB 8
`define REV_MSB 11
`define IRQ_ATTACH 0
`define IRQ_DETACH 1

// reset values
`define RST_PIN_IO 8'h00
`define RST_CLOCK_SELECT 8'h00
`define RST_STATUS_COMMAND 16'h0000
`define RST_IRQ 2'h0

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- pkg/camera_port_pkg.sv
package camera_port_pkg;

	// drive of one two-way pin
	typedef struct packed
	{
		logic out;
		logic oe;
	} pin_drive_s;

	// strap levels caught at reset release
	typedef struct packed
	{
		logic line_b;
		logic line_a;
	} strap_s;

	// write channel held until both halves are in
	typedef struct packed
	{
		logic [13:0] index;
		logic [31:0] data;
		logic [3:0] strb;
	} reg_write_s;

	typedef logic [1:0] irq_bits_t;

endpackage : camera_port_pkg

//--- core/camera_port_config.sv
`timescale 1ns/10ps
`include "camera_port_defines.svh"
module camera_port_config #(
	parameter logic [3:0] REVISION = 4'h5 // arbitrary value
)(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// register bus
	input wire logic [15:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [15:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// configuration straps
	input wire logic CONFIG_STRAP_LINE_A,
	input wire logic CONFIG_STRAP_LINE_B,
	// shared aux pin two (address line eleven)
	input wire logic SHARED_AUX_PIN_TWO_IN,
	output logic SHARED_AUX_PIN_TWO_OUT,
	output logic SHARED_AUX_PIN_TWO_OE,
	// camera side
	input wire logic CABLE_ABSENT,
	input wire logic [7:0] CAMERA_DATA_IN,
	output logic REMOTE_CAMERA_POWER,
	output logic CAMERA_PORT_ENABLE,
	output logic [7:0] CAMERA_CLOCK_SELECT,
	// panel data
	input wire logic [15:0] PANEL_DATA_IN,
	output logic [15:0] PANEL_DATA_BUS,
	// interrupt
	output logic IRQ
);

	logic in_reset; // high until first edge after release
	camera_port_pkg::strap_s strap; // caught strap levels
	logic port_en; // latched camera port enable
	logic [7:0] pin_io_config; // bit 2 drives pin two as output
	logic [7:0] pin_io_level; // bit 2 level of pin two
	logic [7:0] clock_select; // port clock source and divider
	logic remote_power; // power to remote camera
	camera_port_pkg::irq_bits_t irq_status; // sticky events
	camera_port_pkg::irq_bits_t irq_enable; // event mask
	logic cable_absent_q; // previous cable level for edges
	logic aw_held; // address half of a write is in
	logic w_held; // data half of a write is in
	camera_port_pkg::reg_write_s wr; // held write
	logic do_write; // both halves present, response free
	logic [13:0] rd_index; // index of last read, for checks
	camera_port_pkg::pin_drive_s next_pin; // pin two drive
	camera_port_pkg::irq_bits_t next_events; // events this cycle
	camera_port_pkg::irq_bits_t clear_bits; // clear written now

	// byte-lane merge of a write into a narrow register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0])
			res[7:0] = data[7:0];
		if (strb[1])
			res[15:8] = data[15:8];
		return res;
	endfunction : merge

	// decodes whether an index is mapped
	function automatic logic mapped(input logic [13:0] idx);
		case (idx)
			`IDX_PIN_IO_CONFIG, `IDX_PIN_IO_LEVEL, `IDX_STRAP_READBACK, `IDX_CAM_CLOCK_SELECT,
				`IDX_CAM_STATUS_COMMAND, `IDX_IRQ_STATUS, `IDX_IRQ_ENABLE, `IDX_IRQ_CLEAR:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction : mapped

	// strap capture; reset only clears, the level is caught after release
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			in_reset <= 1'b1;
			strap <= '0;
			port_en <= 1'b0;
		end
		else if (in_reset)
		begin
			// first edge after release stands for the reset's rising edge
			in_reset <= 1'b0;
			strap <= {CONFIG_STRAP_LINE_B, CONFIG_STRAP_LINE_A};
			port_en <= CONFIG_STRAP_LINE_A & CONFIG_STRAP_LINE_B;
		end
		// otherwise held: later strap activity is ignored
	end

	assign do_write = aw_held && w_held && !S_AXI_BVALID;

	// write address and data taken independently, in either order
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr <= '0;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held <= 1'b1;
				wr.index <= S_AXI_AWADDR[15:2];
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held <= 1'b1;
				wr.data <= S_AXI_WDATA;
				wr.strb <= S_AXI_WSTRB;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	// ready flops: one item of each half at a time
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
			S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
		end
	end

	// write response one cycle after both halves are in
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `RESP_OKAY;
		end
		else if (do_write)
		begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= mapped(wr.index) ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
			S_AXI_BVALID <= 1'b0;
	end

	// software-written control registers
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			pin_io_config <= `RST_PIN_IO;
			pin_io_level <= `RST_PIN_IO;
			clock_select <= `RST_CLOCK_SELECT;
			remote_power <= 1'(`RST_STATUS_COMMAND >> `BIT_REMOTE_POWER);
			irq_enable <= `RST_IRQ;
		end
		else if (do_write)
		begin
			case (wr.index)
				`IDX_PIN_IO_CONFIG:
					pin_io_config <= 8'(merge({8'h00, pin_io_config}, wr.data, wr.strb));
				`IDX_PIN_IO_LEVEL:
					pin_io_level <= 8'(merge({8'h00, pin_io_level}, wr.data, wr.strb));
				`IDX_CAM_CLOCK_SELECT:
					// range of the resulting clock is software's duty
					clock_select <= 8'(merge({8'h00, clock_select}, wr.data, wr.strb));
				`IDX_CAM_STATUS_COMMAND:
					// only the power bit is writable; status fields are fixed or live
					remote_power <= wr.strb[0] ? wr.data[`BIT_REMOTE_POWER] : remote_power;
				`IDX_IRQ_ENABLE:
					irq_enable <= wr.strb[0] ? wr.data[1:0] : irq_enable;
				default:
					; // read-only, clear and unmapped writes store nothing here
			endcase
		end
	end

	// cable edges become events; none on the first edge after reset, where the old level is only a guess
	always_comb
	begin
		next_events[`IRQ_ATTACH] = !in_reset && cable_absent_q && !CABLE_ABSENT;
		next_events[`IRQ_DETACH] = !in_reset && !cable_absent_q && CABLE_ABSENT;
		clear_bits = (do_write && wr.index == `IDX_IRQ_CLEAR && wr.strb[0]) ? wr.data[1:0] : 2'h0;
	end

	// sticky status; an event in the clearing cycle survives
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			cable_absent_q <= 1'b1;
			irq_status <= `RST_IRQ;
			IRQ <= 1'b0;
		end
		else
		begin
			cable_absent_q <= CABLE_ABSENT;
			irq_status <= (irq_status & ~clear_bits) | next_events;
			IRQ <= |(((irq_status & ~clear_bits) | next_events) & irq_enable);
		end
	end

	// read channel: one read at a time, data one cycle after address
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `RESP_OKAY;
			rd_index <= 14'h0000;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			rd_index <= S_AXI_ARADDR[15:2];
			S_AXI_RRESP <= mapped(S_AXI_ARADDR[15:2]) ? `RESP_OKAY : `RESP_SLVERR;
			S_AXI_RDATA <= 32'h00000000;
			case (S_AXI_ARADDR[15:2])
				`IDX_PIN_IO_CONFIG:
					S_AXI_RDATA[7:0] <= pin_io_config;
				`IDX_PIN_IO_LEVEL:
					// pin two shows its live level when set as input; other bits read the stored level
					S_AXI_RDATA[7:0] <= pin_io_config[`BIT_AUX_PIN_TWO] ? pin_io_level
						: {pin_io_level[7:3], SHARED_AUX_PIN_TWO_IN, pin_io_level[1:0]};
				`IDX_STRAP_READBACK:
				begin
					S_AXI_RDATA[`BIT_STRAP_A] <= strap.line_a;
					S_AXI_RDATA[`BIT_STRAP_B] <= strap.line_b;
				end
				`IDX_CAM_CLOCK_SELECT:
					S_AXI_RDATA[7:0] <= clock_select;
				`IDX_CAM_STATUS_COMMAND:
				begin
					// 16-bit status word; upper lanes read zero
					S_AXI_RDATA[`REV_MSB:`REV_LSB] <= REVISION;
					S_AXI_RDATA[`BIT_CABLE_ABSENT] <= CABLE_ABSENT;
					S_AXI_RDATA[`BIT_REMOTE_POWER] <= remote_power;
				end
				`IDX_IRQ_STATUS:
					S_AXI_RDATA[1:0] <= irq_status;
				`IDX_IRQ_ENABLE:
					S_AXI_RDATA[1:0] <= irq_enable;
				default:
					; // clear register and holes read zero
			endcase
		end
		else if (S_AXI_RVALID)
		begin
			S_AXI_RVALID <= !S_AXI_RREADY;
			S_AXI_ARREADY <= S_AXI_RREADY;
		end
		else
			S_AXI_ARREADY <= 1'b1;
	end

	// owner of pin two: camera port or general-purpose registers
	always_comb
	begin
		if (port_en)
		begin
			next_pin.out = remote_power;
			next_pin.oe = 1'b1;
		end
		else
		begin
			next_pin.out = pin_io_level[`BIT_AUX_PIN_TWO];
			next_pin.oe = pin_io_config[`BIT_AUX_PIN_TWO];
		end
	end

	// registered pin and camera outputs
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			SHARED_AUX_PIN_TWO_OUT <= 1'b0;
			SHARED_AUX_PIN_TWO_OE <= 1'b0;
			REMOTE_CAMERA_POWER <= 1'b0;
			CAMERA_PORT_ENABLE <= 1'b0;
			CAMERA_CLOCK_SELECT <= `RST_CLOCK_SELECT;
		end
		else
		begin
			SHARED_AUX_PIN_TWO_OUT <= next_pin.out;
			SHARED_AUX_PIN_TWO_OE <= next_pin.oe;
			REMOTE_CAMERA_POWER <= port_en && remote_power;
			CAMERA_PORT_ENABLE <= port_en;
			CAMERA_CLOCK_SELECT <= clock_select;
		end
	end

	// panel data: upper byte goes to the camera port when enabled
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			PANEL_DATA_BUS <= 16'h0000;
		else
		begin
			PANEL_DATA_BUS[7:0] <= PANEL_DATA_IN[7:0];
			// 16-bit colour panels lose their upper byte while the camera owns it
			PANEL_DATA_BUS[15:8] <= port_en ? CAMERA_DATA_IN : PANEL_DATA_IN[15:8];
		end
	end

	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);

	sequence s_release;
		in_reset && RST_B;
	endsequence

	sequence s_write_ready;
		aw_held && w_held && !S_AXI_BVALID;
	endsequence

	sequence s_status_read;
		S_AXI_RVALID && rd_index == `IDX_CAM_STATUS_COMMAND;
	endsequence

	chk_strap_latch: assert property (s_release |=> port_en == $past(CONFIG_STRAP_LINE_A && CONFIG_STRAP_LINE_B))
		else $error("enable not latched from straps");
	chk_enable_hold: assert property (!in_reset |=> $stable(port_en) && $stable(strap))
		else $error("latched enable changed");
	chk_pin_owner: assert property (port_en |=> SHARED_AUX_PIN_TWO_OE && SHARED_AUX_PIN_TWO_OUT == $past(remote_power))
		else $error("pin two not driven by power bit");
	chk_camera_power: assert property (##1 REMOTE_CAMERA_POWER == $past(port_en && remote_power))
		else $error("camera power output wrong");
	chk_status_revision: assert property (s_status_read |-> S_AXI_RDATA[11:8] == REVISION && S_AXI_RDATA[31:16] == 16'h0000)
		else $error("revision field wrong");
	chk_cable_bit: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[15:2] == `IDX_CAM_STATUS_COMMAND
		|=> S_AXI_RDATA[7] == $past(CABLE_ABSENT))
		else $error("cable bit wrong");
	chk_strap_read: assert property (S_AXI_RVALID && rd_index == `IDX_STRAP_READBACK && !in_reset
		|-> ((S_AXI_RDATA[7:0] & 8'h60) == 8'h60) == port_en)
		else $error("strap readback disagrees with enable");
	chk_panel_upper: assert property (port_en |=> PANEL_DATA_BUS[15:8] == $past(CAMERA_DATA_IN))
		else $error("panel upper byte not given to camera");
	chk_panel_revert: assert property (!port_en |=> PANEL_DATA_BUS == $past(PANEL_DATA_IN))
		else $error("panel data not passed through");
	chk_write_resp: assert property (s_write_ready |=> S_AXI_BVALID ##0 !aw_held && !w_held)
		else $error("write not answered");

endmodule : camera_port_config

//--- sim/remote_camera_model.sv
`timescale 1ns/10ps
// far-side camera: plug sense and a data stream
module remote_camera_model (
	// clock
	input wire logic MCLK,
	// plug and power
	input wire logic attached,
	input wire logic power,
	output logic cable_absent,
	output logic [7:0] cam_data
);
	// plug sense reads high with no camera attached
	assign cable_absent = ~attached;
	// counts while powered; an unpowered bus flips every cycle so no stale value passes
	// power not yet known counts as off, so the bus never turns unknown
	initial cam_data = 8'h3c;
	always @(posedge MCLK)
	begin
		cam_data <= (power === 1'b1) ? cam_data + 8'h01 : ~cam_data;
	end
endmodule : remote_camera_model

//--- sim/camera_port_config_tb.sv
`timescale 1ns/10ps
`include "camera_port_defines.svh"
module camera_port_config_tb;
	localparam logic [3:0] REV = 4'h5; // arbitrary revision code
	localparam logic [15:0] PIN_IN = 16'ha5c3; // steady panel source
	// bus and pin stimulus
	logic mclk = 0, rst_b = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic sa = 0, sb = 0, attached = 1;
	logic [15:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	// design answers
	logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, power, port_en, irq, absent, pin;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] clk_sel, cam, cam_prev;
	logic [15:0] panel;
	int fails = 0, checked = 0;
	// shared pin two has a pull-up when nobody drives it
	assign pin = pin_oe ? pin_out : 1'b1;
	// what the design sampled from the camera at the last edge
	always @(posedge mclk) cam_prev <= cam;
	initial forever #50 mclk = ~mclk;
	camera_port_config #(.REVISION(REV)) camera_port_config_inst (.MCLK(mclk), .RST_B(rst_b),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .CONFIG_STRAP_LINE_A(sa), .CONFIG_STRAP_LINE_B(sb),
		.SHARED_AUX_PIN_TWO_IN(pin), .SHARED_AUX_PIN_TWO_OUT(pin_out), .SHARED_AUX_PIN_TWO_OE(pin_oe),
		.CABLE_ABSENT(absent), .CAMERA_DATA_IN(cam), .REMOTE_CAMERA_POWER(power),
		.CAMERA_PORT_ENABLE(port_en), .CAMERA_CLOCK_SELECT(clk_sel), .PANEL_DATA_IN(PIN_IN),
		.PANEL_DATA_BUS(panel), .IRQ(irq));
	remote_camera_model remote_camera_model_inst (.MCLK(mclk), .attached(attached), .power(power),
		.cable_absent(absent), .cam_data(cam));
	// byte address of a register index
	function automatic logic [15:0] ba(input logic [13:0] i);
		return {i, 2'b00};
	endfunction : ba
	// counts the comparison, reports a mismatch at once
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one write; address and data offered together, each released once taken
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, done;
		logic [1:0] r;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		n = 0;
		done = 0;
		while (!done && n < 50)
		begin
			@(negedge mclk);
			ta = awv && awready;
			tw = wv && wready;
			done = bvalid;
			r = bresp;
			@(posedge mclk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			n++;
		end
		bready <= 0;
		if (!done) fails++;
		cmp({30'h0, r}, {30'h0, er});
	endtask : wr
	// one read; rready held until the answer is seen
	task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		logic t, done;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge mclk);
		araddr <= a;
		arv <= 1;
		rready <= 1;
		n = 0;
		done = 0;
		while (!done && n < 50)
		begin
			@(negedge mclk);
			t = arv && arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge mclk);
			if (t) arv <= 0;
			n++;
		end
		rready <= 0;
		if (!done) fails++;
		cmp(d, exp);
		cmp({30'h0, r}, {30'h0, er});
	endtask : rd
	// let pin outputs catch up, then look between edges
	task automatic settle;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask : settle
	// reset with given straps, then move the straps to show the latch ignores them
	task automatic restart(input logic a, input logic b);
		@(posedge mclk);
		rst_b <= 0;
		sa <= a;
		sb <= b;
		repeat (6) @(posedge mclk);
		rst_b <= 1;
		repeat (3) @(posedge mclk);
		sa <= ~a;
		sb <= ~b;
		settle();
		cmp({31'h0, port_en}, {31'h0, a & b});
	endtask : restart
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// watchdog far beyond the expected run length
	initial
	begin
		#2000000;
		fails++;
		conclude();
	end
	// main sequence
	initial
	begin
		restart(1, 0);
		rd(ba(`IDX_STRAP_READBACK), 32'h20, `RESP_OKAY);
		rd(ba(`IDX_PIN_IO_LEVEL), 32'h4, `RESP_OKAY);
		wr(ba(`IDX_PIN_IO_CONFIG), 32'h4, `RESP_OKAY);
		wr(ba(`IDX_PIN_IO_LEVEL), 32'h4, `RESP_OKAY);
		wr(ba(`IDX_CAM_STATUS_COMMAND), 32'h0, `RESP_OKAY);
		settle();
		cmp({30'h0, pin_oe, pin_out}, 32'h3);
		cmp({16'h0, panel}, {16'h0, PIN_IN});
		cmp({31'h0, power}, 32'h0);
		restart(1, 1);
		rd(ba(`IDX_STRAP_READBACK), 32'h60, `RESP_OKAY);
		rd(ba(`IDX_IRQ_STATUS), 32'h0, `RESP_OKAY);
		wr(ba(`IDX_PIN_IO_CONFIG), 32'h4, `RESP_OKAY);
		wr(ba(`IDX_PIN_IO_LEVEL), 32'h4, `RESP_OKAY);
		wr(ba(`IDX_CAM_STATUS_COMMAND), 32'h2, `RESP_OKAY);
		settle();
		cmp({29'h0, pin_oe, pin_out, power}, 32'h7);
		cmp({16'h0, panel}, {16'h0, cam_prev, PIN_IN[7:0]});
		rd(ba(`IDX_CAM_STATUS_COMMAND), {20'h0, REV, 8'h02}, `RESP_OKAY);
		wr(ba(`IDX_CAM_STATUS_COMMAND), 32'h0, `RESP_OKAY);
		settle();
		cmp({30'h0, pin_out, power}, 32'h0);
		wr(ba(`IDX_CAM_CLOCK_SELECT), 32'h5a, `RESP_OKAY);
		rd(ba(`IDX_CAM_CLOCK_SELECT), 32'h5a, `RESP_OKAY);
		cmp({24'h0, clk_sel}, 32'h5a);
		wr(16'h0008, 32'h1, `RESP_SLVERR);
		rd(16'h0008, 32'h0, `RESP_SLVERR);
		// camera unplugged with the event enabled
		wr(ba(`IDX_IRQ_ENABLE), 32'h3, `RESP_OKAY);
		rd(ba(`IDX_IRQ_ENABLE), 32'h3, `RESP_OKAY);
		attached <= 0;
		settle();
		cmp({31'h0, irq}, 32'h1);
		rd(ba(`IDX_CAM_STATUS_COMMAND), {20'h0, REV, 8'h80}, `RESP_OKAY);
		rd(ba(`IDX_IRQ_STATUS), 32'h2, `RESP_OKAY);
		wr(ba(`IDX_IRQ_CLEAR), 32'h2, `RESP_OKAY);
		settle();
		cmp({31'h0, irq}, 32'h0);
		rd(ba(`IDX_IRQ_STATUS), 32'h0, `RESP_OKAY);
		// camera plugged back with the event masked
		wr(ba(`IDX_IRQ_ENABLE), 32'h0, `RESP_OKAY);
		attached <= 1;
		settle();
		cmp({31'h0, irq}, 32'h0);
		rd(ba(`IDX_IRQ_STATUS), 32'h1, `RESP_OKAY);
		wr(ba(`IDX_IRQ_ENABLE), 32'h1, `RESP_OKAY);
		settle();
		cmp({31'h0, irq}, 32'h1);
		wr(ba(`IDX_IRQ_CLEAR), 32'h1, `RESP_OKAY);
		settle();
		cmp({31'h0, irq}, 32'h0);
		conclude();
	end
endmodule : camera_port_config_tb
